// *** src/cfrc_params.svh ***
// register offsets, field positions, reset values and counts for the coefficient access block
`ifndef CFRC_PARAMS_SVH
`define CFRC_PARAMS_SVH

`define CFRC_AW              8
`define CFRC_DW              16
`define CFRC_OFS_COEF_ADDR   8'h11
`define CFRC_OFS_COEF_DATA   8'h12
`define CFRC_OFS_RAM_MASK    8'h13
`define CFRC_OFS_DELAY_MASK  8'h14
`define CFRC_OFS_GEN_CTL     8'h15
`define CFRC_OFS_GEN_START   8'h16
`define CFRC_OFS_GEN_STEP    8'h17
`define CFRC_OFS_SW_TRIG     8'h20
`define CFRC_OFS_DELAY0      8'h21
`define CFRC_OFS_DELAY1      8'h22
`define CFRC_OFS_DELAY2      8'h23
`define CFRC_OFS_DELAY3      8'h24
`define CFRC_OFS_STATUS      8'h25
`define CFRC_OFS_EVT_MAP     8'h26
`define CFRC_OFS_EVT_MASK    8'h27

`define CFRC_RST_RAM_MASK    8'hff
`define CFRC_RST_DELAY_MASK  8'hff
`define CFRC_SHADOW_DEPTH    768
`define CFRC_SHADOW_LAST     10'h2ff
`define CFRC_ADDR_W          10
`define CFRC_NUM_RAMS        8
`define CFRC_NUM_STAGES      4
`define CFRC_TRIG_COPY_BIT   5
`define CFRC_TRIG_ALLOC_BIT  6
`define CFRC_CRC_EVT_BIT     7
`define CFRC_ACC_W           18
`define CFRC_LFSR_SEED_I     32'h0000_0001
`define CFRC_LFSR_SEED_Q     32'h8000_0001

`endif

// *** src/cfrc_pkg.sv ***
// types shared by the coefficient access block and its test signal generator
package cfrc_pkg;

   typedef enum logic [1:0] {
      CFRC_GEN_OFF   = 2'b00,
      CFRC_GEN_RAMP  = 2'b01,
      CFRC_GEN_LFSR  = 2'b10,
      CFRC_GEN_EXT   = 2'b11
   } cfrc_mode_t;

   typedef enum logic [0:0] {
      CFRC_CP_IDLE = 1'b0,
      CFRC_CP_RUN  = 1'b1
   } cfrc_copy_t;

endpackage

// *** src/cfrc_siggen.sv ***
// test signal generator that feeds the first cancellation stage
`timescale 1ns/1ps
`include "cfrc_params.svh"

module cfrc_siggen #(
   parameter int ACC_W = `CFRC_ACC_W
) (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire cfrc_pkg::cfrc_mode_t mode,
   input  wire logic [15:0]        start_val,
   input  wire logic [15:0]        step_val,
   input  wire logic               reload,
   input  wire logic               sample_valid,
   input  wire logic [ACC_W-1:0]   in_i,
   input  wire logic [ACC_W-1:0]   in_q,
   input  wire logic [ACC_W-1:0]   ext_i,
   input  wire logic [ACC_W-1:0]   ext_q,
   output logic      [ACC_W-1:0]   out_i,
   output logic      [ACC_W-1:0]   out_q,
   output logic                    crc_en
);
   import cfrc_pkg::*;

   logic [ACC_W-1:0] acc_q, acc_d;
   logic [31:0]      lfsr_i_q, lfsr_q_q;
   logic [ACC_W-1:0] out_i_q, out_q_q;
   logic             crc_en_q;

   wire [ACC_W-1:0] start_ext = {{(ACC_W-16){start_val[15]}}, start_val};  // R12
   wire [ACC_W-1:0] step_ext  = {{(ACC_W-16){step_val[15]}}, step_val};
   wire             is_ramp   = (mode == CFRC_GEN_RAMP);
   wire             is_lfsr   = (mode == CFRC_GEN_LFSR);
   wire [ACC_W-1:0] acc_rev   = {<<{acc_q}};  // R15

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // four summed uniform bytes are near gaussian, giving roughly 10 dB peak to average
   function automatic logic [ACC_W-1:0] lfsr_shape(input logic [31:0] s);
      logic [9:0] sum;
      sum = {{2{s[7]}}, s[7:0]} + {{2{s[15]}}, s[15:8]}
          + {{2{s[23]}}, s[23:16]} + {{2{s[31]}}, s[31:24]};
      lfsr_shape = {sum, {(ACC_W-10){1'b0}}};
   endfunction

   // the start value is held while not ramping, so a ramp always begins there
   assign acc_d = (reload || !is_ramp) ? start_ext :                 // R12
                  (sample_valid ? acc_q + step_ext : acc_q);         // R10 R13 R23

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         acc_q    <= '0;
         lfsr_i_q <= `CFRC_LFSR_SEED_I;
         lfsr_q_q <= `CFRC_LFSR_SEED_Q;
      end else begin
         acc_q <= acc_d;
         if (is_lfsr && sample_valid) begin
            lfsr_i_q <= lfsr_next(lfsr_i_q);  // R11
            lfsr_q_q <= lfsr_next(lfsr_q_q);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         out_i_q  <= '0;
         out_q_q  <= '0;
         crc_en_q <= 1'b0;
      end else begin
         crc_en_q <= (mode != CFRC_GEN_OFF);  // R09
         unique case (mode)
            CFRC_GEN_OFF: begin
               out_i_q <= in_i;
               out_q_q <= in_q;
            end
            CFRC_GEN_RAMP: begin
               out_i_q <= acc_q;  // R14
               out_q_q <= acc_rev;  // R15
            end
            CFRC_GEN_LFSR: begin
               out_i_q <= lfsr_shape(lfsr_i_q);  // R11
               out_q_q <= lfsr_shape(lfsr_q_q);
            end
            CFRC_GEN_EXT: begin
               out_i_q <= ext_i;
               out_q_q <= ext_q;
            end
         endcase
      end
   end

   assign out_i  = out_i_q;
   assign out_q  = out_q_q;
   assign crc_en = crc_en_q;

endmodule // cfrc_siggen

// *** src/cfrc_regs.sv ***
// coefficient shadow ram access, update masks, delay loading and test generator registers
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "cfrc_params.svh"

// Summary of operation
// R01 - ten-bit shadow address, locations 0 to 767
// R02 - data access auto-increments the shadow address
// R03 - data register moves full 16-bit words
// R04 - only masked canceler rams receive copies
// R05 - host keeps stage canceler counts summing <=8
// R06 - four-bit stage mask gates delay loads
// R07 - each stage holds its own pulse delay
// R08 - host updates canceler rams a subset at a time
// R09 - two-bit mode selects generator, enables crc
// R10 - mode 01: dc if step zero, else sawtooth
// R11 - lfsr mode gives noise near 10 dB PAR
// R12 - 18-bit accumulator loaded sign-extended from start
// R13 - signed step added every input sample
// R14 - generator replaces first stage inputs; I=accumulator
// R15 - bit-reversed accumulator drives the Q input
// R16 - crc ready sets map bit 7, masked interrupt
// R17 - host clears map bit 7 before next interrupt
// R18 - host neutralises stages to see generator output
// R19 - host uses pulse length 15 up to 101
// R20 - copy trigger copies shadow into selected rams
// R21 - writing 0x20 to trigger fires copy only
// R22 - delay event loads delays of masked stages
// R23 - accumulator wraps modulo 2^18
// R24 - auto-increment past 767 wraps to 0
module cfrc_regs #(
   parameter int AW     = `CFRC_AW,
   parameter int DW     = `CFRC_DW,
   parameter int ACC_W  = `CFRC_ACC_W,
   parameter int DEPTH  = `CFRC_SHADOW_DEPTH,
   parameter int NRAM   = `CFRC_NUM_RAMS,
   parameter int NSTAGE = `CFRC_NUM_STAGES
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic [AW-1:0]         reg_addr,
   input  wire logic [DW-1:0]         reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [DW-1:0]         reg_rdata,
   input  wire logic                  sample_valid,
   input  wire logic [ACC_W-1:0]      in_i,
   input  wire logic [ACC_W-1:0]      in_q,
   input  wire logic [ACC_W-1:0]      ext_i,
   input  wire logic [ACC_W-1:0]      ext_q,
   input  wire logic                  cancel_sync_evt,
   input  wire logic                  delay_sync_evt,
   input  wire logic                  crc_done,
   output logic      [ACC_W-1:0]      stage1_i,
   output logic      [ACC_W-1:0]      stage1_q,
   output logic                       crc_enable,
   output logic                       copy_we,
   output logic      [9:0]            copy_addr,
   output logic      [15:0]           copy_data,
   output logic      [NRAM-1:0]       copy_ram_sel,
   output logic                       copy_busy,
   output logic      [NSTAGE*16-1:0]  stage_delay,
   output logic                       sw_alloc_trig,
   output logic                       crc_irq
);
   import cfrc_pkg::*;

   // shadow ram and its pointer
   logic [15:0]            shadow_mem [0:DEPTH-1];
   logic [9:0]             coef_addr_q;
   logic [9:0]             coef_addr_d;

   // software registers
   logic [7:0]             ram_mask_q;
   logic [7:0]             delay_mask_q;
   cfrc_mode_t             gen_mode_q;
   logic [15:0]            gen_start_q;
   logic [15:0]            gen_step_q;
   logic [NSTAGE-1:0][15:0] delay_shadow_q;
   logic [NSTAGE-1:0][15:0] delay_live_q;
   logic                   evt_map_q;
   logic                   evt_mask_q;
   logic                   irq_q;
   logic                   alloc_trig_q;
   logic [DW-1:0]          rdata_q;

   // copy sequencer
   cfrc_copy_t             cp_state_q;
   logic [9:0]             cp_cnt_q;
   logic [NRAM-1:0]        cp_sel_q;
   logic                   cp_we_q;
   logic [9:0]             cp_addr_q;
   logic [15:0]            cp_data_q;
   logic                   cp_busy_q;

   // register decode
   wire wr_addr   = reg_wr && (reg_addr == `CFRC_OFS_COEF_ADDR);
   wire wr_data   = reg_wr && (reg_addr == `CFRC_OFS_COEF_DATA);
   wire rd_data   = reg_rd && (reg_addr == `CFRC_OFS_COEF_DATA);
   wire wr_rmask  = reg_wr && (reg_addr == `CFRC_OFS_RAM_MASK);
   wire wr_dmask  = reg_wr && (reg_addr == `CFRC_OFS_DELAY_MASK);
   wire wr_ctl    = reg_wr && (reg_addr == `CFRC_OFS_GEN_CTL);
   wire wr_start  = reg_wr && (reg_addr == `CFRC_OFS_GEN_START);
   wire wr_step   = reg_wr && (reg_addr == `CFRC_OFS_GEN_STEP);
   wire wr_trig   = reg_wr && (reg_addr == `CFRC_OFS_SW_TRIG);
   wire wr_map    = reg_wr && (reg_addr == `CFRC_OFS_EVT_MAP);
   wire wr_mask   = reg_wr && (reg_addr == `CFRC_OFS_EVT_MASK);
   wire addr_ok   = (coef_addr_q <= `CFRC_SHADOW_LAST);

   // software and external copy triggers share the sequencer
   wire sw_copy   = wr_trig && reg_wdata[`CFRC_TRIG_COPY_BIT];  // R21
   wire copy_go   = sw_copy || cancel_sync_evt;  // R20
   wire cp_last   = (cp_cnt_q == `CFRC_SHADOW_LAST);

   // a stale address beyond the last location reads as zero and ignores writes
   wire [15:0] mem_rd = addr_ok ? shadow_mem[coef_addr_q] : 16'h0000;  // R03

   // every data access steps the pointer, wrapping after the last location
   assign coef_addr_d = wr_addr ? reg_wdata[9:0] :                       // R01
                        (wr_data || rd_data) ?                           // R02
                        ((coef_addr_q >= `CFRC_SHADOW_LAST) ? 10'h000 :  // R24
                         coef_addr_q + 10'h001) :
                        coef_addr_q;

   // read data mux, unmapped offsets read zero
   wire [DW-1:0] rd_mux =
      (reg_addr == `CFRC_OFS_COEF_ADDR)  ? {6'h00, coef_addr_q} :  // R01
      (reg_addr == `CFRC_OFS_COEF_DATA)  ? mem_rd :                // R03
      (reg_addr == `CFRC_OFS_RAM_MASK)   ? {8'h00, ram_mask_q} :
      (reg_addr == `CFRC_OFS_DELAY_MASK) ? {8'h00, delay_mask_q} :
      (reg_addr == `CFRC_OFS_GEN_CTL)    ? {14'h0000, gen_mode_q} :
      (reg_addr == `CFRC_OFS_GEN_START)  ? gen_start_q :
      (reg_addr == `CFRC_OFS_GEN_STEP)   ? gen_step_q :
      (reg_addr == `CFRC_OFS_DELAY0)     ? delay_shadow_q[0] :
      (reg_addr == `CFRC_OFS_DELAY1)     ? delay_shadow_q[1] :
      (reg_addr == `CFRC_OFS_DELAY2)     ? delay_shadow_q[2] :
      (reg_addr == `CFRC_OFS_DELAY3)     ? delay_shadow_q[3] :
      (reg_addr == `CFRC_OFS_STATUS)     ? {15'h0000, cp_state_q == CFRC_CP_RUN} :
      (reg_addr == `CFRC_OFS_EVT_MAP)    ? {8'h00, evt_map_q, 7'h00} :
      (reg_addr == `CFRC_OFS_EVT_MASK)   ? {8'h00, evt_mask_q, 7'h00} :
      16'h0000;

   // shadow ram write port, no reset needed on storage
   always_ff @(posedge sys_clk) begin
      if (wr_data && addr_ok) begin
         shadow_mem[coef_addr_q] <= reg_wdata;  // R03
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         coef_addr_q <= 10'h000;
         rdata_q     <= 16'h0000;
      end else begin
         coef_addr_q <= coef_addr_d;  // R02
         rdata_q     <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // control registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ram_mask_q   <= `CFRC_RST_RAM_MASK;
         delay_mask_q <= `CFRC_RST_DELAY_MASK;
         gen_mode_q   <= CFRC_GEN_OFF;
         gen_start_q  <= 16'h0000;
         gen_step_q   <= 16'h0000;
      end else begin
         if (wr_rmask) begin
            ram_mask_q <= reg_wdata[7:0];  // R04
         end
         if (wr_dmask) begin
            delay_mask_q <= reg_wdata[7:0];  // R06
         end
         if (wr_ctl) begin
            gen_mode_q <= cfrc_mode_t'(reg_wdata[1:0]);  // R09
         end
         if (wr_start) begin
            gen_start_q <= reg_wdata;  // R12
         end
         if (wr_step) begin
            gen_step_q <= reg_wdata;  // R13
         end
      end
   end

   // per-stage delays: written value waits for the update event
   genvar g;
   generate
      for (g = 0; g < NSTAGE; g++) begin : g_stage
         wire wr_dly = reg_wr && (reg_addr == `CFRC_OFS_DELAY0 + AW'(g));
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               delay_shadow_q[g] <= 16'h0000;
               delay_live_q[g]   <= 16'h0000;
            end else begin
               if (wr_dly) begin
                  delay_shadow_q[g] <= reg_wdata;  // R07
               end
               if (delay_sync_evt && delay_mask_q[g]) begin
                  delay_live_q[g] <= delay_shadow_q[g];  // R22
               end
            end
         end
      end
   endgenerate

   // copy sequencer walks the whole shadow ram once per trigger;
   // a trigger during a walk is dropped; the walk carries later writes only to words it has not yet copied
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cp_state_q <= CFRC_CP_IDLE;
         cp_cnt_q   <= 10'h000;
         cp_sel_q   <= '0;
         cp_we_q    <= 1'b0;
         cp_addr_q  <= 10'h000;
         cp_data_q  <= 16'h0000;
         cp_busy_q  <= 1'b0;
      end else begin
         unique case (cp_state_q)
            CFRC_CP_IDLE: begin
               cp_we_q <= 1'b0;
               // busy spans the trailing write cycle, so no glue logic sits on the output
               cp_busy_q <= copy_go;  // R20
               if (copy_go) begin
                  cp_state_q <= CFRC_CP_RUN;  // R20
                  cp_cnt_q   <= 10'h000;
                  cp_sel_q   <= ram_mask_q[NRAM-1:0];  // R04
               end
            end
            CFRC_CP_RUN: begin
               cp_we_q   <= 1'b1;
               cp_busy_q <= 1'b1;
               cp_addr_q <= cp_cnt_q;
               cp_data_q <= shadow_mem[cp_cnt_q];  // R20
               cp_cnt_q  <= cp_cnt_q + 10'h001;
               if (cp_last) begin
                  cp_state_q <= CFRC_CP_IDLE;
               end
            end
         endcase
      end
   end

   // crc ready flag: a new event wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         evt_map_q    <= 1'b0;
         evt_mask_q   <= 1'b0;
         irq_q        <= 1'b0;
         alloc_trig_q <= 1'b0;
      end else begin
         if (crc_done) begin
            evt_map_q <= 1'b1;  // R16
         end else if (wr_map && reg_wdata[`CFRC_CRC_EVT_BIT]) begin
            evt_map_q <= 1'b0;  // R17
         end
         if (wr_mask) begin
            evt_mask_q <= reg_wdata[`CFRC_CRC_EVT_BIT];
         end
         irq_q        <= evt_map_q && evt_mask_q;  // R16
         alloc_trig_q <= wr_trig && reg_wdata[`CFRC_TRIG_ALLOC_BIT];
      end
   end

   cfrc_siggen #(
      .ACC_W        (ACC_W)
   ) u_siggen (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .mode         (gen_mode_q),
      .start_val    (gen_start_q),
      .step_val     (gen_step_q),
      .reload       (wr_start),
      .sample_valid (sample_valid),
      .in_i         (in_i),
      .in_q         (in_q),
      .ext_i        (ext_i),
      .ext_q        (ext_q),
      .out_i        (stage1_i),
      .out_q        (stage1_q),
      .crc_en       (crc_enable)
   );

   assign reg_rdata     = rdata_q;
   assign copy_we       = cp_we_q;
   assign copy_addr     = cp_addr_q;
   assign copy_data     = cp_data_q;
   assign copy_ram_sel  = cp_sel_q;
   assign copy_busy     = cp_busy_q;
   assign stage_delay   = delay_live_q;
   assign sw_alloc_trig = alloc_trig_q;
   assign crc_irq       = irq_q;

endmodule // cfrc_regs

// *** tb/cfrc_regs_chk.sv ***
// concurrent checks on the coefficient access register block
`timescale 1ns/1ps
module cfrc_regs_chk #(
   parameter int NSTAGE = 4
) (
   input wire logic                sys_clk,
   input wire logic                rst,
   input wire logic [7:0]          reg_addr,
   input wire logic [15:0]         reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [15:0]         reg_rdata,
   input wire logic                cancel_sync_evt,
   input wire logic                delay_sync_evt,
   input wire logic                crc_done,
   input wire logic                crc_enable,
   input wire logic                copy_we,
   input wire logic [9:0]          copy_addr,
   input wire logic [7:0]          copy_ram_sel,
   input wire logic                copy_busy,
   input wire logic [NSTAGE*16-1:0] stage_delay,
   input wire logic                sw_alloc_trig,
   input wire logic                crc_irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire       trig_wr = reg_wr && reg_addr == 8'h20;
   wire       mask_wr = reg_wr && reg_addr == 8'h27;
   wire       mode_wr = reg_wr && reg_addr == 8'h15;
   wire [1:0] wmode   = reg_wdata[1:0];
   // a trigger during a walk is dropped, so only idle triggers are checked
   sequence copy_req;
      ((trig_wr && reg_wdata[5]) || cancel_sync_evt) && !copy_busy;
   endsequence
   sequence copy_begin;
      copy_busy ##1 (copy_we && copy_addr == 10'h000);
   endsequence
   chk_copy_start: assert property (copy_req |=> copy_begin)
      else $error("copy walk did not start at word zero");
   chk_copy_step: assert property (copy_we && copy_addr != 10'h2ff |=> copy_we && copy_addr == $past(copy_addr) + 10'h001)
      else $error("copy walk skipped or stalled");
   chk_copy_end: assert property (copy_we && copy_addr == 10'h2ff |=> !copy_we)
      else $error("copy walk ran past the last word");
   chk_sel_hold: assert property (copy_we |-> copy_busy && $stable(copy_ram_sel))
      else $error("ram select moved during a walk");
   chk_copy_only: assert property (trig_wr && !reg_wdata[6] |=> !sw_alloc_trig)
      else $error("copy trigger also fired allocation");
   chk_alloc_pulse: assert property (trig_wr && reg_wdata[6] |=> sw_alloc_trig)
      else $error("allocation trigger missing");
   chk_delay_hold: assert property (!delay_sync_evt |=> $stable(stage_delay))
      else $error("stage delay changed without an event");
   chk_crc_mode: assert property (mode_wr |-> ##2 crc_enable == ($past(wmode, 2) != 2'b00))
      else $error("crc enable does not follow mode");
   chk_irq_cause: assert property ($rose(crc_irq) |-> $past(crc_done, 2) || $past(mask_wr, 2))
      else $error("interrupt rose without cause");
   chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
endmodule // cfrc_regs_chk

bind cfrc_regs cfrc_regs_chk #(.NSTAGE(NSTAGE)) u_chk (.*);

// *** tb/cfrc_ram_sink.sv ***
// canceler ram bank model that receives copied coefficient words
`timescale 1ns/1ps
module cfrc_ram_sink (
   input wire logic        sys_clk,
   input wire logic        clr,
   input wire logic        copy_we,
   input wire logic [9:0]  copy_addr,
   input wire logic [15:0] copy_data,
   input wire logic [7:0]  copy_ram_sel
);
   // only first and last words kept: enough to see order and wrap
   int          n_words   [8];
   logic [15:0] word0     [8];
   logic [15:0] word_last [8];
   always @(posedge sys_clk) begin
      for (int k = 0; k < 8; k++) begin
         if (clr) n_words[k] = 0;
         else if (copy_we === 1'b1 && copy_ram_sel[k] === 1'b1) begin
            n_words[k]++;
            if (copy_addr == 10'h000) word0[k] = copy_data;
            if (copy_addr == 10'h2ff) word_last[k] = copy_data;
         end
      end
   end
endmodule // cfrc_ram_sink

// *** tb/testbench.sv ***
// self-checking bench for the coefficient access register block
`timescale 1ns/1ps
module testbench;
   logic        sys_clk = 1'b0, rst = 1'b1, clr = 1'b0, rd_d = 1'b0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, sample_valid = 1'b0;
   logic        cancel_sync_evt = 1'b0, delay_sync_evt = 1'b0, crc_done = 1'b0;
   logic [7:0]  reg_addr = 8'h00, copy_ram_sel, m;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, copy_data;
   logic [17:0] in_i, in_q, ext_i, ext_q, stage1_i, stage1_q, acc;
   logic        crc_enable, copy_we, copy_busy, sw_alloc_trig, crc_irq;
   logic [9:0]  copy_addr;
   logic [63:0] stage_delay, exp_d;
   logic [31:0] seed = 32'h0000e519;
   logic [15:0] w [3];
   logic [15:0] q [$];
   logic [7:0]  ofs [8] = '{8'h11, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h20, 8'h30};
   logic [15:0] rv [8] = '{16'h0000, 16'h00ff, 16'h00ff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0] st [3] = '{16'h8001, 16'h7fff, 16'h0010};
   logic [15:0] sp [3] = '{16'h0000, 16'h7fff, 16'hfff8};
   logic [15:0] dm [2] = '{16'hfff5, 16'h000a};
   int          n_mismatch = 0, total_checks = 0, n;

   cfrc_regs u_dut (.*);
   cfrc_ram_sink u_sink (.*);

   always #2.5 sys_clk = ~sys_clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [17:0] rev(input logic [17:0] a);
      for (int i = 0; i < 18; i++) rev[i] = a[17 - i];
   endfunction
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic rd, input logic [7:0] a, input logic [15:0] d);
      reg_wr <= wr;
      reg_rd <= rd;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
   endtask
   task automatic idle(input int c);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (c) @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      q.push_back(exp);
      bus(1'b0, 1'b1, a, 16'h0000);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // read data belongs to the read one cycle earlier
   always @(posedge sys_clk) begin
      if (rd_d) cmp(reg_rdata, q.pop_front());
      rd_d = reg_rd;
   end

   initial begin
      in_i <= 18'(rnd());
      in_q <= 18'(rnd());
      ext_i <= 18'(rnd());
      ext_q <= 18'(rnd());
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) rd(ofs[i], rv[i]);
      bus(1'b1, 1'b0, 8'h11, 16'h02fe);
      for (int i = 0; i < 3; i++) begin
         w[i] = 16'(rnd());
         bus(1'b1, 1'b0, 8'h12, w[i]);
      end
      rd(8'h11, 16'h0001);
      bus(1'b1, 1'b0, 8'h11, 16'h02fe);
      for (int i = 0; i < 3; i++) rd(8'h12, w[i]);
      rd(8'h11, 16'h0001);
      for (int t = 0; t < 2; t++) begin
         m = 8'(rnd());
         clr <= 1'b1;
         bus(1'b1, 1'b0, 8'h13, {8'h00, m});
         clr <= 1'b0;
         cancel_sync_evt <= t[0];
         bus(t == 0, 1'b0, 8'h20, 16'h0020);
         cancel_sync_evt <= 1'b0;
         idle(10);
         bus(1'b1, 1'b0, 8'h20, 16'h0060);
         idle(1);
         for (n = 0; copy_busy === 1'b1 && n < 1000; n++) @(posedge sys_clk);
         if (n == 1000) begin
            n_mismatch++;
            give_verdict();
         end
         for (int k = 0; k < 8; k++) begin
            cmp(u_sink.n_words[k], m[k] ? 768 : 0);
            if (m[k]) cmp({u_sink.word0[k], u_sink.word_last[k]}, {w[2], w[1]});
         end
      end
      exp_d = 64'h0;
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 4; k++) begin
            w[0] = 16'(15 + rnd() % 87);
            bus(1'b1, 1'b0, 8'h21 + 8'(k), w[0]);
            if (dm[r][k]) exp_d[16*k +: 16] = w[0];
         end
         bus(1'b1, 1'b0, 8'h14, dm[r]);
         delay_sync_evt <= 1'b1;
         idle(1);
         delay_sync_evt <= 1'b0;
         idle(1);
         cmp(stage_delay, exp_d);
      end
      for (int md = 0; md < 4; md++) begin
         bus(1'b1, 1'b0, 8'h15, 16'(md));
         idle(3);
         cmp(crc_enable, md != 0);
         if (md == 0) cmp({stage1_i, stage1_q}, {in_i, in_q});
         if (md == 3) cmp({stage1_i, stage1_q}, {ext_i, ext_q});
         if (md == 2) begin
            acc = stage1_i;
            sample_valid <= 1'b1;
            idle(1);
            sample_valid <= 1'b0;
            idle(3);
            cmp(stage1_i != acc, 1'b1);
         end
      end
      for (int p = 0; p < 3; p++) begin
         bus(1'b1, 1'b0, 8'h15, 16'h0000);
         bus(1'b1, 1'b0, 8'h16, st[p]);
         bus(1'b1, 1'b0, 8'h17, sp[p]);
         bus(1'b1, 1'b0, 8'h15, 16'h0001);
         idle(3);
         acc = {{2{st[p][15]}}, st[p]};
         for (int s = 0; s < 10; s++) begin
            cmp(stage1_i, acc);
            cmp(stage1_q, rev(acc));
            sample_valid <= 1'b1;
            idle(1);
            sample_valid <= 1'b0;
            idle(3);
            acc = acc + {{2{sp[p][15]}}, sp[p]};
         end
      end
      bus(1'b1, 1'b0, 8'h27, 16'h0080);
      crc_done <= 1'b1;
      idle(1);
      crc_done <= 1'b0;
      idle(3);
      cmp(crc_irq, 1'b1);
      rd(8'h26, 16'h0080);
      bus(1'b1, 1'b0, 8'h26, 16'h0080);
      idle(3);
      cmp(crc_irq, 1'b0);
      bus(1'b1, 1'b0, 8'h27, 16'h0000);
      crc_done <= 1'b1;
      idle(1);
      crc_done <= 1'b0;
      idle(3);
      cmp(crc_irq, 1'b0);
      rd(8'h26, 16'h0080);
      idle(2);
      give_verdict();
   end
endmodule // testbench
